// *** msq_pkg.sv ***
// package: constants, register layouts and types of the mode sequencer
package msq_pkg;
  localparam int AW = 4;
  localparam int DW = 32;
  localparam int RES_W = 24;
  localparam int RATE_N = 32;
  localparam int Q8_W = 11;
  localparam int CLK_HZ = 32'h05f5e100;

  // register indices on the plain port
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_MEAS = 4'h1;
  localparam logic [AW-1:0] REG_STBY = 4'h2;
  localparam logic [AW-1:0] REG_STAT = 4'h3;
  localparam logic [AW-1:0] REG_PRES = 4'h4;
  localparam logic [AW-1:0] REG_TEMP = 4'h5;
  localparam logic [AW-1:0] REG_CMD  = 4'h6;
  localparam logic [AW-1:0] REG_LIM  = 4'h7;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h5a;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0, MODE_PER = 2'h1, MODE_ONE = 2'h2, MODE_B2B = 2'h3
  } msq_mode_t;

  typedef enum logic [4:0] {
    IDLE_STATE         = 5'h01,
    DORMANT_STATE      = 5'h02,
    ONE_SHOT_STATE     = 5'h04,
    PERIODIC_STATE     = 5'h08,
    BACK_TO_BACK_STATE = 5'h10
  } msq_state_t;

  // register layouts, msb first
  typedef struct packed {
    logic       low_power_inhibit;
    logic [4:0] sample_rate_select;
    logic [1:0] operating_mode_select;
  } msq_ctrl_t;
  typedef struct packed {
    logic       press_en;
    logic [2:0] press_avg_ratio;
    logic [2:0] temp_avg_ratio;
  } msq_meas_t;
  typedef struct packed {
    logic [2:0] press_smoothing_coef;
    logic [2:0] temp_smoothing_coef;
    logic [1:0] queue_frame_select;
  } msq_stby_t;
  typedef struct packed {
    logic [4:0] state;
    logic       rate_config_ok;
    logic [2:0] press_avg_applied;
    logic [2:0] temp_avg_applied;
  } msq_stat_t;
  typedef struct packed {
    logic [RES_W-1:0] press;
    logic [RES_W-1:0] temp;
  } msq_result_t;
  typedef struct packed {
    logic       press_en;
    logic [2:0] temp_avg;
    logic [2:0] press_avg;
    logic [2:0] temp_coef;
    logic [2:0] press_coef;
  } msq_conv_cfg_t;

  localparam msq_ctrl_t CTRL_RST = '{1'b0, 5'h1f, 2'h0};
  localparam msq_meas_t MEAS_RST = '{1'b0, 3'h0, 3'h0};
  localparam msq_stby_t STBY_RST = '{3'h0, 3'h0, 2'h0};
  localparam logic [2:0] AVG_X1 = 3'h0;
  localparam logic [2:0] AVG_X2 = 3'h1;
  localparam logic [2:0] COEF_BYPASS = 3'h0;
  localparam logic [1:0] QUEUE_OFF = 2'h0;
  // rates in eighths of a hertz
  localparam logic [Q8_W-1:0] DORMANT_BELOW_Q8 = 11'h028;
  localparam logic [Q8_W-1:0] FALLBACK_Q8 = 11'h500;
  localparam logic [2:0] Q8_SHIFT = 3'h0;

  // sample rate per select code: 240 Hz down to 0.125 Hz
  localparam logic [Q8_W-1:0] RATE_Q8 [RATE_N] = '{
    11'h780, 11'h6e0, 11'h640, 11'h5a0, 11'h500, 11'h4b0, 11'h460,
    11'h410, 11'h3c0, 11'h370, 11'h320, 11'h2d0, 11'h280, 11'h230,
    11'h1e0, 11'h190, 11'h168, 11'h140, 11'h118, 11'h0f0, 11'h0c8,
    11'h0a0, 11'h078, 11'h050, 11'h028, 11'h020, 11'h018, 11'h010,
    11'h008, 11'h004, 11'h002, 11'h001};

  // highest rate in hertz, indexed by {press ratio, temp ratio}
  localparam logic [7:0] MAX_PAIR_HZ [64] = '{
    8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hc8, 8'h82, 8'h50, 8'h28,
    8'hf0, 8'hf0, 8'hf0, 8'hdc, 8'hb4, 8'h78, 8'h46, 8'h28,
    8'hdc, 8'hdc, 8'hc8, 8'hb4, 8'h8c, 8'h64, 8'h46, 8'h28,
    8'h8c, 8'h8c, 8'h82, 8'h78, 8'h64, 8'h50, 8'h32, 8'h23,
    8'h50, 8'h50, 8'h50, 8'h46, 8'h46, 8'h32, 8'h2d, 8'h1e,
    8'h2d, 8'h2d, 8'h28, 8'h28, 8'h28, 8'h23, 8'h1e, 8'h14,
    8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h0f, 8'h0f,
    8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h05};
  // highest rate in hertz for temperature only, by temp ratio
  localparam logic [7:0] MAX_TEMP_HZ [8] = '{
    8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hc8, 8'h82, 8'h50, 8'h28};
endpackage

// *** msq_mode_seq.sv ***
// measurement mode sequencer: modes, rate check, registers
//
// The plain strobed port and the register offsets were chosen for this implementation.
module msq_mode_seq #(
  parameter int TICKS_PER_SEC = msq_pkg::CLK_HZ
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  input  wire logic [msq_pkg::AW-1:0] reg_addr_in,
  input  wire logic [msq_pkg::DW-1:0] reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [msq_pkg::DW-1:0] reg_rdata_out,
  output logic                        conv_start_out,
  output msq_pkg::msq_conv_cfg_t      conv_cfg_out,
  input  wire logic                   conv_done_in,
  input  wire msq_pkg::msq_result_t   conv_result_in,
  output logic                        queue_push_out,
  output msq_pkg::msq_result_t        queue_data_out,
  output logic      [1:0]             queue_frame_sel_out,
  output logic                        dormant_out
);
  msq_pkg::msq_state_t  state;
  msq_pkg::msq_state_t  next_state;
  msq_pkg::msq_ctrl_t   ctrl;
  msq_pkg::msq_meas_t   meas;
  msq_pkg::msq_stby_t   stby;
  msq_pkg::msq_result_t result;
  msq_pkg::msq_result_t qdata;
  logic [2:0]           temp_applied;
  logic [2:0]           press_applied;
  logic                 rate_config_ok;
  logic                 busy;
  logic                 start_q;
  logic                 push_q;
  logic [31:0]          wait_cnt;
  logic [31:0]          rdata;
  logic [31:0]          period_tab [msq_pkg::RATE_N];

  // address decode
  wire sel_ctrl = reg_addr_in == msq_pkg::REG_CTRL;
  wire sel_meas = reg_addr_in == msq_pkg::REG_MEAS;
  wire sel_stby = reg_addr_in == msq_pkg::REG_STBY;
  wire sel_stat = reg_addr_in == msq_pkg::REG_STAT;
  wire sel_pres = reg_addr_in == msq_pkg::REG_PRES;
  wire sel_temp = reg_addr_in == msq_pkg::REG_TEMP;
  wire sel_cmd  = reg_addr_in == msq_pkg::REG_CMD;
  wire sel_lim  = reg_addr_in == msq_pkg::REG_LIM;
  wire wr_ctrl  = reg_wr_in && sel_ctrl;
  wire wr_meas  = reg_wr_in && sel_meas;
  wire wr_stby  = reg_wr_in && sel_stby;
  wire soft_rst = reg_wr_in && sel_cmd &&
                  reg_wdata_in[$bits(msq_pkg::SOFT_RESET_CODE)-1:0] ==
                  msq_pkg::SOFT_RESET_CODE;

  // state shorthands
  wire st_idle = state == msq_pkg::IDLE_STATE;
  wire st_dorm = state == msq_pkg::DORMANT_STATE;
  wire st_one  = state == msq_pkg::ONE_SHOT_STATE;
  wire st_per  = state == msq_pkg::PERIODIC_STATE;
  wire st_b2b  = state == msq_pkg::BACK_TO_BACK_STATE;
  wire active  = st_one || st_per || st_b2b;
  wire next_per = next_state == msq_pkg::PERIODIC_STATE;
  wire next_active = next_state != msq_pkg::IDLE_STATE &&
                     next_state != msq_pkg::DORMANT_STATE;
  wire [1:0] mode_req = ctrl.operating_mode_select;
  // an active mode stays only while software still asks for it
  wire stay = (st_one && mode_req == msq_pkg::MODE_ONE) ||
              (st_per && mode_req == msq_pkg::MODE_PER) ||
              (st_b2b && mode_req == msq_pkg::MODE_B2B);

  // mode in effect, not the request, is what software reads back
  wire [1:0] mode_eff = st_one ? msq_pkg::MODE_ONE :
                        st_per ? msq_pkg::MODE_PER :
                        st_b2b ? msq_pkg::MODE_B2B : msq_pkg::MODE_IDLE;

  // rate and its cap for the current ratios
  wire [msq_pkg::Q8_W-1:0] rate_q8 =
    msq_pkg::RATE_Q8[ctrl.sample_rate_select];
  wire press_on = meas.press_en || stby.queue_frame_select[1];
  wire [7:0] max_hz = press_on ?
    msq_pkg::MAX_PAIR_HZ[{meas.press_avg_ratio,
                          meas.temp_avg_ratio}] :
    msq_pkg::MAX_TEMP_HZ[meas.temp_avg_ratio];
  wire [msq_pkg::Q8_W-1:0] limit_q8 = {max_hz, msq_pkg::Q8_SHIFT};
  wire combo_bad = rate_q8 > limit_q8;
  wire check_on  = st_per && press_on;

  // every dormant condition must hold at once
  wire dormant_ok = !ctrl.low_power_inhibit &&
                    rate_q8 < msq_pkg::DORMANT_BELOW_Q8 &&
                    stby.queue_frame_select == msq_pkg::QUEUE_OFF &&
                    stby.temp_smoothing_coef == msq_pkg::COEF_BYPASS &&
                    stby.press_smoothing_coef == msq_pkg::COEF_BYPASS;

  // filter and queue fields only take writes while not measuring
  wire stby_open = st_idle || st_dorm;

  // period in clock cycles for every rate code
  for (genvar g = 0; g < msq_pkg::RATE_N; g++) begin : g_period
    assign period_tab[g] = 32'((64'(TICKS_PER_SEC) * 64'h8) /
                               64'(msq_pkg::RATE_Q8[g]));
  end
  wire [31:0] period = period_tab[ctrl.sample_rate_select];

  // conversion launch: at once on entry, then by rate or back to back
  wire enter_start = st_idle && next_active;
  wire per_start   = st_per && stay && !busy &&
                     wait_cnt == 32'h0;
  wire b2b_start   = st_b2b && stay && !busy;
  wire meas_start  = !soft_rst &&
                     (enter_start || per_start || b2b_start);
  wire done_ok     = conv_done_in && busy;

  // mode transitions; active modes never switch among themselves
  always_comb begin
    next_state = state;
    case (state)
      msq_pkg::DORMANT_STATE: begin
        if (mode_req != msq_pkg::MODE_IDLE || !dormant_ok) begin
          next_state = msq_pkg::IDLE_STATE;
        end
      end
      msq_pkg::IDLE_STATE: begin
        case (mode_req)
          msq_pkg::MODE_ONE: next_state = msq_pkg::ONE_SHOT_STATE;
          msq_pkg::MODE_PER: next_state = msq_pkg::PERIODIC_STATE;
          msq_pkg::MODE_B2B: next_state = msq_pkg::BACK_TO_BACK_STATE;
          default: begin
            if (dormant_ok) begin
              next_state = msq_pkg::DORMANT_STATE;
            end
          end
        endcase
      end
      msq_pkg::ONE_SHOT_STATE: begin
        if (!stay || done_ok) begin
          next_state = msq_pkg::IDLE_STATE;
        end
      end
      msq_pkg::PERIODIC_STATE, msq_pkg::BACK_TO_BACK_STATE: begin
        if (!stay) begin
          next_state = msq_pkg::IDLE_STATE;
        end
      end
      default: next_state = msq_pkg::IDLE_STATE;
    endcase
  end

  // write data seen through the control layout, no bit positions here
  wire msq_pkg::msq_ctrl_t ctrl_wval =
    reg_wdata_in[$bits(msq_pkg::msq_ctrl_t)-1:0];
  // a new write of the mode wins over the one-shot self clear
  wire [1:0] next_mode = wr_ctrl ?
    ctrl_wval.operating_mode_select :
    (st_one && done_ok) ? msq_pkg::MODE_IDLE : mode_req;
  wire msq_pkg::msq_ctrl_t next_ctrl = wr_ctrl ?
    '{ctrl_wval.low_power_inhibit, ctrl_wval.sample_rate_select,
      next_mode} :
    '{ctrl.low_power_inhibit, ctrl.sample_rate_select, next_mode};

  // fallback ratios when a periodic run with pressure on starts out of range
  wire fallback = next_per && press_on && combo_bad;
  wire [2:0] fb_avg = (rate_q8 >= msq_pkg::FALLBACK_Q8) ?
                      msq_pkg::AVG_X1 : msq_pkg::AVG_X2;
  wire [2:0] next_temp_applied = !meas_start ? temp_applied :
    fallback ? fb_avg : meas.temp_avg_ratio;
  wire [2:0] next_press_applied = !meas_start ? press_applied :
    fallback ? fb_avg : meas.press_avg_ratio;

  // rest of period, counted from the start of each measurement
  wire [31:0] next_wait = meas_start ? period - 32'h1 :
    (st_per && wait_cnt != 32'h0) ? wait_cnt - 32'h1 : 32'h0;

  // leaving for idle abandons a running conversion
  wire next_busy = meas_start || (busy && !conv_done_in && next_active);

  // read mux; unmapped and command reads return zero
  wire msq_pkg::msq_stat_t status =
    '{state, rate_config_ok, press_applied, temp_applied};
  wire [31:0] rd_word =
    sel_ctrl ? 32'({ctrl.low_power_inhibit,
                    ctrl.sample_rate_select, mode_eff}) :
    sel_meas ? 32'(meas) :
    sel_stby ? 32'(stby) :
    sel_stat ? 32'(status) :
    sel_pres ? 32'(result.press) :
    sel_temp ? 32'(result.temp) :
    sel_lim  ? 32'(limit_q8) : 32'h0;

  // mode state; soft reset lands in dormant like power-up
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= msq_pkg::DORMANT_STATE;
    end else if (soft_rst) begin
      state <= msq_pkg::DORMANT_STATE;
    end else begin
      state <= next_state;
    end
  end

  // software registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= msq_pkg::CTRL_RST;
      meas <= msq_pkg::MEAS_RST;
      stby <= msq_pkg::STBY_RST;
    end else if (soft_rst) begin
      ctrl <= msq_pkg::CTRL_RST;
      meas <= msq_pkg::MEAS_RST;
      stby <= msq_pkg::STBY_RST;
    end else begin
      ctrl <= next_ctrl;
      if (wr_meas) begin
        meas <= reg_wdata_in[$bits(msq_pkg::msq_meas_t)-1:0];
      end
      if (wr_stby && stby_open) begin
        stby <= reg_wdata_in[$bits(msq_pkg::msq_stby_t)-1:0];
      end
    end
  end

  // measurement sequencing and applied ratios
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy          <= 1'b0;
      start_q       <= 1'b0;
      wait_cnt      <= 32'h0;
      temp_applied  <= msq_pkg::AVG_X1;
      press_applied <= msq_pkg::AVG_X1;
    end else if (soft_rst) begin
      busy          <= 1'b0;
      start_q       <= 1'b0;
      wait_cnt      <= 32'h0;
      temp_applied  <= msq_pkg::AVG_X1;
      press_applied <= msq_pkg::AVG_X1;
    end else begin
      busy          <= next_busy;
      start_q       <= meas_start;
      wait_cnt      <= next_wait;
      temp_applied  <= next_temp_applied;
      press_applied <= next_press_applied;
    end
  end

  // check flag follows the live settings while periodic
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rate_config_ok <= 1'b1;
    end else begin
      rate_config_ok <= soft_rst || !(check_on && combo_bad);
    end
  end

  // results change only when a conversion completes or a soft reset clears them
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result <= '0;
      qdata  <= '0;
      push_q <= 1'b0;
    end else if (soft_rst) begin
      result <= '0;
      push_q <= 1'b0;
    end else begin
      if (done_ok) begin
        result <= conv_result_in;
        qdata  <= conv_result_in;
      end
      // queue is never flushed here, so idle keeps its entries
      push_q <= done_ok && (st_per || st_b2b) &&
                stby.queue_frame_select != msq_pkg::QUEUE_OFF;
    end
  end

  // registered read port: data only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata <= 32'h0;
    end else begin
      rdata <= reg_rd_in ? rd_word : 32'h0;
    end
  end

  assign reg_rdata_out       = rdata;
  assign conv_start_out      = start_q;
  assign conv_cfg_out        = '{meas.press_en, temp_applied, press_applied,
                                 stby.temp_smoothing_coef,
                                 stby.press_smoothing_coef};
  assign queue_push_out      = push_q;
  assign queue_data_out      = qdata;
  assign queue_frame_sel_out = stby.queue_frame_select;
  assign dormant_out         = st_dorm;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_soft_dormant: assert property (
    soft_rst |=> st_dorm && !busy)
    else $error("soft reset did not land in dormant");
  chk_via_idle: assert property (
    active && next_state != state && !soft_rst |=> st_idle)
    else $error("active mode left without idle");
  chk_idle_quiet: assert property (
    conv_start_out |-> active)
    else $error("conversion started outside active mode");
  chk_result_hold: assert property (
    !done_ok && !soft_rst |=> $stable(result))
    else $error("results changed without a completed measurement");
  chk_dorm_enter: assert property (
    !st_dorm ##1 st_dorm && !$past(soft_rst) |-> $past(dormant_ok))
    else $error("dormant entered without its conditions");
  chk_dorm_exit: assert property (
    st_dorm && !dormant_ok && !soft_rst |=> st_idle)
    else $error("dormant kept after a condition dropped");
  chk_one_return: assert property (
    st_one && done_ok && !soft_rst && !wr_ctrl
    |=> st_idle && mode_eff == msq_pkg::MODE_IDLE ##1 !conv_start_out)
    else $error("one-shot did not return to idle once");
  chk_first_start: assert property (
    st_idle && next_active && !soft_rst |=> conv_start_out && busy)
    else $error("first measurement not started on entry");
  chk_stby_drop: assert property (
    wr_stby && !stby_open && !soft_rst |=> $stable(stby))
    else $error("standby-only write taken while measuring");
  chk_ok_flag: assert property (
    check_on && combo_bad && !soft_rst |=> !rate_config_ok)
    else $error("invalid combination not flagged");
  chk_fallback: assert property (
    meas_start && fallback && rate_q8 >= msq_pkg::FALLBACK_Q8
    |=> temp_applied == msq_pkg::AVG_X1 &&
        press_applied == msq_pkg::AVG_X1)
    else $error("fallback ratios not forced to one");
  chk_period_gap: assert property (
    st_per && (busy || wait_cnt != 32'h0) |=> !conv_start_out)
    else $error("periodic start before period end or completion");
  // a start latches the ratios, a completion latches the results
  chk_ratio_take: assert property (
    meas_start && !fallback
    |=> temp_applied == $past(meas.temp_avg_ratio) &&
        press_applied == $past(meas.press_avg_ratio))
    else $error("applied ratios differ from the settings");
  chk_result_take: assert property (
    done_ok && !soft_rst |=> result == $past(conv_result_in))
    else $error("completed measurement not stored");
  chk_fallback_two: assert property (
    meas_start && fallback && rate_q8 < msq_pkg::FALLBACK_Q8
    |=> temp_applied == msq_pkg::AVG_X2 &&
        press_applied == msq_pkg::AVG_X2)
    else $error("fallback ratios not forced to two");
  chk_ok_restore: assert property (
    !(check_on && combo_bad) |=> rate_config_ok)
    else $error("rate flag cleared while the check is off");
endmodule

// *** msq_mode_seq_tb.sv ***
// self-checking testbench for the measurement mode sequencer
module msq_mode_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // short tick count keeps a 10 Hz period at 100 cycles
  localparam int TICKS = 1000;

  logic                        clk_in         = 1'b0;
  logic                        rst_b_in       = 1'b0;
  logic [msq_pkg::AW-1:0]      reg_addr_in    = '0;
  logic [msq_pkg::DW-1:0]      reg_wdata_in   = '0;
  logic                        reg_wr_in      = 1'b0;
  logic                        reg_rd_in      = 1'b0;
  logic [msq_pkg::DW-1:0]      reg_rdata_out;
  logic                        conv_start_out;
  msq_pkg::msq_conv_cfg_t      conv_cfg_out;
  logic                        conv_done_in   = 1'b0;
  msq_pkg::msq_result_t        conv_result_in = '0;
  logic                        queue_push_out;
  msq_pkg::msq_result_t        queue_data_out;
  logic [1:0]                  queue_frame_sel_out;
  logic                        dormant_out;
  int                          mismatches     = 0;
  int                          num_checks     = 0;

  always #5 clk_in = ~clk_in;

  msq_mode_seq #(.TICKS_PER_SEC(TICKS)) dut_u (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .conv_start_out(conv_start_out), .conv_cfg_out(conv_cfg_out),
    .conv_done_in(conv_done_in), .conv_result_in(conv_result_in),
    .queue_push_out(queue_push_out), .queue_data_out(queue_data_out),
    .queue_frame_sel_out(queue_frame_sel_out), .dormant_out(dormant_out)
  );

  // expected words built from the field layouts
  function automatic logic [31:0] stat_w(input logic [4:0] s,
      input logic ok, input logic [2:0] p, input logic [2:0] t);
    return {20'h0, s, ok, p, t};
  endfunction
  function automatic logic [7:0] ctrl_w(input logic i,
      input logic [4:0] r, input logic [1:0] m);
    return {i, r, m};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one write cycle on the plain port
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= {24'h0, d};
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // read cycle; data is looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, e);
  endtask

  // bounded wait for a conversion start; a hang ends the run
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (conv_start_out !== 1'b1 && n < 500);
    if (conv_start_out !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: no conversion start", $time);
      final_report();
    end
  endtask

  task automatic done(input msq_pkg::msq_result_t r);
    @(posedge clk_in);
    conv_done_in   <= 1'b1;
    conv_result_in <= r;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
    #1;
  endtask

  // counts starts over a stretch where none may occur
  task automatic quiet(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(posedge clk_in);
      #1;
      if (conv_start_out !== 1'b0) cnt++;
    end
  endtask

  // main sequence
  initial begin
    int n;
    time t0;
    msq_pkg::msq_result_t r1;
    msq_pkg::msq_result_t r2;
    r1 = {24'h123456, 24'h00abcd};
    r2 = {24'h654321, 24'h00dcba};
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd_chk(msq_pkg::REG_STAT, stat_w(msq_pkg::DORMANT_STATE, 1, 0, 0));
    rd_chk(msq_pkg::REG_CTRL, {24'h0, ctrl_w(0, 5'h1f, 0)});
    rd_chk(msq_pkg::REG_MEAS, 32'h0);
    check(32'(dormant_out), 32'h1);
    // queue on breaks a dormant condition
    wr(msq_pkg::REG_STBY, 8'h01);
    rd_chk(msq_pkg::REG_STAT, stat_w(msq_pkg::IDLE_STATE, 1, 0, 0));
    rd_chk(msq_pkg::REG_STBY, 32'h1);
    check(32'(queue_frame_sel_out), 32'h1);
    // one-shot at 10 Hz, temperature only
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd23, 2));
    wait_start(n);
    check(32'(n >= 1 && n <= 2), 32'h1);
    check(32'(conv_cfg_out.press_en), 32'h0);
    done(r1);
    check(32'(queue_push_out), 32'h0);
    rd_chk(msq_pkg::REG_PRES, {8'h0, r1.press});
    rd_chk(msq_pkg::REG_TEMP, {8'h0, r1.temp});
    rd_chk(msq_pkg::REG_CTRL, {24'h0, ctrl_w(0, 5'd23, 0)});
    quiet(150, n);
    check(32'(n), 32'h0);
    // a further sample needs a fresh request; the host paces fast rates
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd0, 2));
    wait_start(n);
    check(32'(n), 32'h1);
    done(r2);
    rd_chk(msq_pkg::REG_TEMP, {8'h0, r2.temp});
    // rate caps in eighths of a hertz: x16 temp only is 200 Hz
    wr(msq_pkg::REG_MEAS, 8'h04);
    rd_chk(msq_pkg::REG_LIM, 32'h640);
    // periodic at 10 Hz with x128/x128: invalid, falls back to x2
    wr(msq_pkg::REG_MEAS, 8'h7f);
    rd_chk(msq_pkg::REG_LIM, 32'h28);
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd23, 1));
    wait_start(n);
    t0 = $time;
    rd_chk(msq_pkg::REG_STAT,
           stat_w(msq_pkg::PERIODIC_STATE, 0, 1, 1));
    check(32'(conv_cfg_out.press_avg), 32'(msq_pkg::AVG_X2));
    check(32'(conv_cfg_out.temp_avg), 32'(msq_pkg::AVG_X2));
    check(32'(conv_cfg_out.press_en), 32'h1);
    wr(msq_pkg::REG_STBY, 8'h00);
    rd_chk(msq_pkg::REG_STBY, 32'h1);
    rd_chk(msq_pkg::REG_CTRL, {24'h0, ctrl_w(0, 5'd23, 1)});
    done(r2);
    check(32'(queue_push_out), 32'h1);
    check(32'(queue_data_out.press), {8'h0, r2.press});
    rd_chk(msq_pkg::REG_PRES, {8'h0, r2.press});
    wait_start(n);
    n = int'(($time - t0) / 10);
    check(32'(n >= 99 && n <= 101), 32'h1);
    // leave mid-conversion: a late completion must be ignored
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd23, 0));
    done(r1);
    rd_chk(msq_pkg::REG_PRES, {8'h0, r2.press});
    check(32'(queue_data_out.press), {8'h0, r2.press});
    check(32'(queue_push_out), 32'h0);
    rd_chk(msq_pkg::REG_STAT, stat_w(msq_pkg::IDLE_STATE, 1, 1, 1));
    // back-to-back: no rate check, ratios used as set
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd4, 3));
    wait_start(n);
    rd_chk(msq_pkg::REG_STAT,
           stat_w(msq_pkg::BACK_TO_BACK_STATE, 1, 7, 7));
    rd_chk(msq_pkg::REG_CTRL, {24'h0, ctrl_w(0, 5'd4, 3)});
    // straight to periodic at 160 Hz costs one idle cycle
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd4, 1));
    wait_start(n);
    check(32'(n >= 2 && n <= 3), 32'h1);
    rd_chk(msq_pkg::REG_STAT,
           stat_w(msq_pkg::PERIODIC_STATE, 0, 0, 0));
    check(32'(conv_cfg_out.press_avg), 32'(msq_pkg::AVG_X1));
    // dormant entry at the 5 Hz boundary
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd24, 0));
    wr(msq_pkg::REG_STBY, 8'h00);
    repeat (4) @(posedge clk_in);
    check(32'(dormant_out), 32'h0);
    wr(msq_pkg::REG_CTRL, ctrl_w(0, 5'd25, 0));
    repeat (4) @(posedge clk_in);
    check(32'(dormant_out), 32'h1);
    wr(msq_pkg::REG_CTRL, ctrl_w(1, 5'd25, 0));
    repeat (4) @(posedge clk_in);
    check(32'(dormant_out), 32'h0);
    // soft reset returns everything but the queue data to its reset value
    wr(msq_pkg::REG_CMD, msq_pkg::SOFT_RESET_CODE);
    repeat (2) @(posedge clk_in);
    check(32'(dormant_out), 32'h1);
    rd_chk(msq_pkg::REG_MEAS, 32'h0);
    rd_chk(msq_pkg::REG_STAT, stat_w(msq_pkg::DORMANT_STATE, 1, 0, 0));
    rd_chk(4'hf, 32'h0);
    final_report();
  end
endmodule
